// ===== cfg2_pkg.sv
// constants for the second configuration register bank of the octal flash
// Operation
// - mode field: 00 serial, 01 single-rate, 10 double-rate
// - reset loads mode from one-time default bits
// - default bits: 01 double, 10 single, 11 serial
// - bit 1 enables strobe in single-rate transfers
// - bit 0 adds one strobe pre-cycle
// - three-bit dummy selector, resets to zero
// - selector 000 gives 20, step down two
// - two-bit field picks error pin condition
// - bit 4 enables crc output pin
// - preamble select picks dummy-cycle pattern
// - valid flag set once address recorded
// - status bits: one-bit, two-bit, double-programmed
// - failure counter counts every fail, saturates 15
// - only first one-bit or two-bit failing chunk address captured
// - captured address split over four registers
// - active-low one-time bit enables parity check
// - check fail flag set on fail, cleared on pass
// - write needs latch set; write clears latch
package cfg2_pkg;
  // register offsets
  localparam logic [31:0] OFF_MODE     = 32'h0000_0000;
  localparam logic [31:0] OFF_STROBE   = 32'h0000_0200;
  localparam logic [31:0] OFF_DUMMY    = 32'h0000_0300;
  localparam logic [31:0] OFF_ERRPIN   = 32'h0000_0400;
  localparam logic [31:0] OFF_CRC      = 32'h0000_0500;
  localparam logic [31:0] OFF_ECC      = 32'h0000_0800;
  localparam logic [31:0] OFF_FA0      = 32'h0000_0C00;
  localparam logic [31:0] OFF_FA1      = 32'h0000_0D00;
  localparam logic [31:0] OFF_FA2      = 32'h0000_0E00;
  localparam logic [31:0] OFF_FA3      = 32'h0000_0F00;
  localparam logic [31:0] OFF_OTP      = 32'h4000_0000;
  localparam logic [31:0] OFF_CHK      = 32'h8000_0000;
  // writable masks
  localparam logic [7:0]  MASK_CRC     = 8'h71;
  // interface mode codes
  localparam logic [1:0]  MODE_SERIAL  = 2'h0;
  localparam logic [1:0]  MODE_SINGLE  = 2'h1;
  localparam logic [1:0]  MODE_DOUBLE  = 2'h2;
  localparam logic [1:0]  MODE_BAD     = 2'h3;
  localparam logic [1:0]  DEF_BAD      = 2'h0;
  // dummy cycles
  localparam logic [4:0]  DUMMY_MAX    = 5'h14;
  localparam logic [4:0]  CRC_MIN_LOG  = 5'h4;
  // preamble words for lane patterns
  localparam logic [15:0] PRE_FIXED    = 16'h349A;
  localparam logic [15:0] PRE_ALT      = 16'h5555;
  localparam logic [3:0]  ECC_CNT_MAX  = 4'hF;
  // link framing: opcode, four address bytes, data byte
  localparam logic [7:0]  OP_WR_ENABLE = 8'h01;
  localparam logic [7:0]  OP_WRITE2    = 8'h02;
  localparam logic [7:0]  OP_READ2     = 8'h03;
  localparam logic [6:0]  BIT_OP_END   = 7'h07;
  localparam logic [6:0]  BIT_ADDR_END = 7'h27;
  localparam logic [6:0]  BIT_WR_END   = 7'h2F;
  localparam logic [6:0]  RD_DUMMY     = 7'h14;
  localparam logic [6:0]  BIT_RD_START = BIT_ADDR_END + RD_DUMMY + 7'h01;
  localparam logic [6:0]  BIT_RD_END   = BIT_RD_START + 7'h07;
endpackage

// ===== cfg2_bank.sv
// second configuration register bank with serial register access port
`timescale 1ns/1ns
module cfg2_bank (
  // core clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // register access link
  input  wire logic        link_sclk,
  input  wire logic        link_cs_n,
  input  wire logic        link_si,
  output logic             link_so,
  output logic             link_so_oe,
  // one-time programmable fuses
  input  wire logic [1:0]  otp_default_mode,
  input  wire logic        otp_parity_check_disable_n,
  // array events
  input  wire logic        ecc_chunk_fail,
  input  wire logic [2:0]  ecc_fail_kind,
  input  wire logic [25:4] ecc_fail_addr,
  input  wire logic        check_fail,
  input  wire logic        check_pass,
  // configuration outputs
  output logic             double_rate_octal_enable,
  output logic             single_rate_octal_enable,
  output logic             strobe_in_single_rate,
  output logic             strobe_precycle,
  output logic [4:0]       dummy_cycles,
  output logic [7:0]       crc_chunk_bytes,
  output logic             crc_pin_enable,
  output logic [15:0]      preamble_word,
  output logic             ecc_error_pin_n,
  output logic             parity_check_enable,
  output logic             write_enable_latch
);
  function automatic logic [4:0] dummy_count(input logic [2:0] sel);
    dummy_count = cfg2_pkg::DUMMY_MAX - {1'b0, sel, 1'b0};
  endfunction

  function automatic logic err_match(input logic [1:0] cond, input logic [2:0] st);
    case (cond)
      2'h0:    err_match = st[1] | st[2];
      2'h1:    err_match = |st;
      2'h2:    err_match = st[1];
      default: err_match = st[0] | st[1];
    endcase
  endfunction

  // ---------------- link domain ----------------
  logic [6:0]  cnt_q, cnt_d;
  logic [7:0]  op_q, op_d;
  logic [31:0] addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        cmplt_q, cmplt_d;
  logic        rd_pend_q, rd_pend_d;
  logic        so_d, so_oe_d;
  logic [7:0]  rd_data_q;

  always_comb begin
    cnt_d     = cnt_q + 7'h01;
    op_d      = op_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    cmplt_d   = cmplt_q;
    rd_pend_d = rd_pend_q;
    if (cnt_q == 7'h00) begin
      cmplt_d = 1'b0;
    end
    if (cnt_q <= cfg2_pkg::BIT_OP_END) begin
      op_d = {op_q[6:0], link_si};
    end else if (cnt_q <= cfg2_pkg::BIT_ADDR_END) begin
      addr_d = {addr_q[30:0], link_si};
    end else if (cnt_q <= cfg2_pkg::BIT_WR_END) begin
      wdata_d = {wdata_q[6:0], link_si};
    end
    if (cnt_q == cfg2_pkg::BIT_OP_END && {op_q[6:0], link_si} == cfg2_pkg::OP_WR_ENABLE) begin
      cmplt_d = 1'b1;
    end
    if (cnt_q == cfg2_pkg::BIT_WR_END && op_q == cfg2_pkg::OP_WRITE2) begin
      cmplt_d = 1'b1;
    end
    if (cnt_q == cfg2_pkg::BIT_ADDR_END && op_q == cfg2_pkg::OP_READ2) begin
      rd_pend_d = 1'b1;
    end
    if (cnt_q == 7'h7F) begin
      cnt_d = cnt_q;
    end
  end

  // frame state clears while select is high; the link clock stops between frames
  always_ff @(posedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      cnt_q     <= 7'h00;
      rd_pend_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      rd_pend_q <= rd_pend_d;
    end
  end

  // command fields hold after the frame so the core can pick them up
  always_ff @(posedge link_sclk) begin
    op_q    <= op_d;
    addr_q  <= addr_d;
    wdata_q <= wdata_d;
    cmplt_q <= cmplt_d;
  end

  // read data is stable long before use: the dummy gap covers the crossing
  always_comb begin
    so_d    = 1'b0;
    so_oe_d = 1'b0;
    if (op_q == cfg2_pkg::OP_READ2 && cnt_q >= cfg2_pkg::BIT_RD_START
        && cnt_q <= cfg2_pkg::BIT_RD_END) begin
      so_d    = rd_data_q[3'h7 - 3'(cnt_q - cfg2_pkg::BIT_RD_START)];
      so_oe_d = 1'b1;
    end
  end

  always_ff @(negedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      link_so    <= 1'b0;
      link_so_oe <= 1'b0;
    end else begin
      link_so    <= so_d;
      link_so_oe <= so_oe_d;
    end
  end

  // ---------------- crossings into core ----------------
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic rp_s1_q, rp_s2_q, rp_s3_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      rp_s1_q <= 1'b0;
      rp_s2_q <= 1'b0;
      rp_s3_q <= 1'b0;
    end else begin
      cs_s1_q <= link_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      rp_s1_q <= rd_pend_q;
      rp_s2_q <= rp_s1_q;
      rp_s3_q <= rp_s2_q;
    end
  end

  logic frame_end, read_req;
  assign frame_end = cs_s2_q & ~cs_s3_q;
  assign read_req  = rp_s2_q & ~rp_s3_q;

  // ---------------- core registers ----------------
  logic [1:0]  mode_q, mode_d;
  logic [1:0]  strobe_q, strobe_d;
  logic [2:0]  dsel_q, dsel_d;
  logic [1:0]  pin_cond_q, pin_cond_d;
  logic [7:0]  crc_q, crc_d;
  logic        vld_q, vld_d;
  logic [2:0]  stat_q, stat_d;
  logic [3:0]  ecnt_q, ecnt_d;
  logic [25:4] fa_q, fa_d;
  logic        chk_q, chk_d;
  logic        wr_latch_q, wr_latch_d;
  logic [1:0]  otp_mode_q;
  logic        otp_par_n_q;
  logic [7:0]  rd_data_d;
  logic        do_write;

  assign do_write = frame_end && cmplt_q && op_q == cfg2_pkg::OP_WRITE2 && wr_latch_q;

  always_comb begin
    mode_d   = mode_q;
    strobe_d = strobe_q;
    dsel_d   = dsel_q;
    pin_cond_d = pin_cond_q;
    crc_d    = crc_q;
    vld_d    = vld_q;
    stat_d   = stat_q;
    ecnt_d   = ecnt_q;
    fa_d     = fa_q;
    chk_d    = chk_q;
    wr_latch_d = wr_latch_q;
    if (frame_end && cmplt_q && op_q == cfg2_pkg::OP_WR_ENABLE) begin
      wr_latch_d = 1'b1;
    end
    if (do_write) begin
      wr_latch_d = 1'b0;
      case (addr_q)
        cfg2_pkg::OFF_MODE: begin
          if (wdata_q[1:0] != cfg2_pkg::MODE_BAD) begin
            mode_d = wdata_q[1:0];
          end
        end
        cfg2_pkg::OFF_STROBE: strobe_d = wdata_q[1:0];
        cfg2_pkg::OFF_DUMMY:  dsel_d = wdata_q[2:0];
        cfg2_pkg::OFF_ERRPIN: pin_cond_d = wdata_q[1:0];
        cfg2_pkg::OFF_CRC:    crc_d = wdata_q & cfg2_pkg::MASK_CRC;
        default: ;
      endcase
    end
    if (ecc_chunk_fail) begin
      stat_d = stat_q | ecc_fail_kind;
      if (ecnt_q != cfg2_pkg::ECC_CNT_MAX) begin
        ecnt_d = ecnt_q + 4'h1;
      end
      if (!vld_q && |ecc_fail_kind[1:0]) begin
        vld_d = 1'b1;
        fa_d  = ecc_fail_addr;
      end
    end
    // a fail in the same cycle as a pass wins
    if (check_pass) begin
      chk_d = 1'b0;
    end
    if (check_fail) begin
      chk_d = 1'b1;
    end
  end

  always_comb begin
    rd_data_d = rd_data_q;
    if (read_req) begin
      case (addr_q)
        cfg2_pkg::OFF_MODE:   rd_data_d = {6'h00, mode_q};
        cfg2_pkg::OFF_STROBE: rd_data_d = {6'h00, strobe_q};
        cfg2_pkg::OFF_DUMMY:  rd_data_d = {5'h00, dsel_q};
        cfg2_pkg::OFF_ERRPIN: rd_data_d = {6'h00, pin_cond_q};
        cfg2_pkg::OFF_CRC:    rd_data_d = crc_q;
        cfg2_pkg::OFF_ECC:    rd_data_d = {vld_q, stat_q, ecnt_q};
        cfg2_pkg::OFF_FA0:    rd_data_d = {fa_q[7:4], 4'h0};
        cfg2_pkg::OFF_FA1:    rd_data_d = fa_q[15:8];
        cfg2_pkg::OFF_FA2:    rd_data_d = fa_q[23:16];
        cfg2_pkg::OFF_FA3:    rd_data_d = {6'h00, fa_q[25:24]};
        cfg2_pkg::OFF_OTP:    rd_data_d = {4'h0, otp_par_n_q, 1'b0, otp_mode_q};
        cfg2_pkg::OFF_CHK:    rd_data_d = {3'h0, chk_q, 4'h0};
        default:              rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      // fuses are caught by the synchronous reset, so mode follows them
      otp_mode_q  <= otp_default_mode;
      otp_par_n_q <= otp_parity_check_disable_n;
      if (otp_default_mode == cfg2_pkg::DEF_BAD) begin
        mode_q <= cfg2_pkg::MODE_SERIAL;
      end else begin
        mode_q <= ~otp_default_mode;
      end
      strobe_q  <= 2'h0;
      dsel_q    <= 3'h0;
      pin_cond_q <= 2'h0;
      crc_q     <= 8'h00;
      vld_q     <= 1'b0;
      stat_q    <= 3'h0;
      ecnt_q    <= 4'h0;
      fa_q      <= 22'h000000;
      chk_q     <= 1'b0;
      wr_latch_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      mode_q    <= mode_d;
      strobe_q  <= strobe_d;
      dsel_q    <= dsel_d;
      pin_cond_q <= pin_cond_d;
      crc_q     <= crc_d;
      vld_q     <= vld_d;
      stat_q    <= stat_d;
      ecnt_q    <= ecnt_d;
      fa_q      <= fa_d;
      chk_q     <= chk_d;
      wr_latch_q <= wr_latch_d;
      rd_data_q <= rd_data_d;
    end
  end

  // outputs other than parity_check_enable registered from the next values so they track with no extra lag
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      double_rate_octal_enable <= 1'b0;
      single_rate_octal_enable <= 1'b0;
      strobe_in_single_rate    <= 1'b0;
      strobe_precycle          <= 1'b0;
      dummy_cycles             <= cfg2_pkg::DUMMY_MAX;
      crc_chunk_bytes          <= 8'h10;
      crc_pin_enable           <= 1'b0;
      preamble_word            <= cfg2_pkg::PRE_FIXED;
      ecc_error_pin_n          <= 1'b1;
      parity_check_enable      <= 1'b0;
      write_enable_latch       <= 1'b0;
    end else begin
      double_rate_octal_enable <= mode_d == cfg2_pkg::MODE_DOUBLE;
      single_rate_octal_enable <= mode_d == cfg2_pkg::MODE_SINGLE;
      strobe_in_single_rate    <= strobe_d[1];
      strobe_precycle          <= strobe_d[0];
      dummy_cycles             <= dummy_count(dsel_d);
      crc_chunk_bytes          <= 8'h01 << (cfg2_pkg::CRC_MIN_LOG + {3'h0, crc_d[6:5]});
      crc_pin_enable           <= crc_d[4];
      preamble_word            <= crc_d[0] ? cfg2_pkg::PRE_ALT : cfg2_pkg::PRE_FIXED;
      ecc_error_pin_n          <= ~err_match(pin_cond_d, stat_d);
      parity_check_enable      <= ~otp_par_n_q;
      write_enable_latch       <= wr_latch_d;
    end
  end
endmodule

// ===== cfg2_bank_checker.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ns
module cfg2_bank_checker (
  // clock, reset and link select
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        link_cs_n,
  // fuses and events
  input wire logic [1:0]  otp_default_mode,
  input wire logic        otp_parity_check_disable_n,
  input wire logic        ecc_chunk_fail,
  // observed outputs
  input wire logic        double_rate_octal_enable,
  input wire logic        single_rate_octal_enable,
  input wire logic [4:0]  dummy_cycles,
  input wire logic [7:0]  crc_chunk_bytes,
  input wire logic [15:0] preamble_word,
  input wire logic        ecc_error_pin_n,
  input wire logic        parity_check_enable,
  input wire logic        write_enable_latch
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_mode_legal: assert property (
    !(double_rate_octal_enable && single_rate_octal_enable)) else $error("both modes set");
  // mode outputs hold reset values at release, fuse value one edge later
  a_mode_fuse: assert property ($rose(nrst) |=>
    double_rate_octal_enable == (otp_default_mode == 2'h1) &&
    single_rate_octal_enable == (otp_default_mode == 2'h2)) else $error("mode not from fuse");
  a_reset_vals: assert property (disable iff (1'b0) !nrst |=>
    dummy_cycles == 5'h14 && crc_chunk_bytes == 8'h10 && preamble_word == 16'h349A &&
    ecc_error_pin_n && !write_enable_latch) else $error("reset values wrong");
  a_chunk_size: assert property (
    crc_chunk_bytes inside {8'h10, 8'h20, 8'h40, 8'h80}) else $error("bad chunk size");
  a_pre_word: assert property (
    preamble_word inside {16'h349A, 16'h5555}) else $error("bad preamble word");
  a_parity_fuse: assert property ($past(nrst) |->
    parity_check_enable == !otp_parity_check_disable_n) else $error("parity enable wrong");
  a_pin_cause: assert property ($fell(ecc_error_pin_n) |->
    $past(ecc_chunk_fail) || $past(ecc_chunk_fail, 2)) else $error("pin fell unprompted");
  a_latch_idle: assert property ($rose(write_enable_latch) |->
    link_cs_n && $past(link_cs_n, 2)) else $error("latch set inside frame");
  c_double: cover property (double_rate_octal_enable);
  c_pin: cover property ($fell(ecc_error_pin_n));
  c_latch: cover property ($rose(write_enable_latch));
endmodule
bind cfg2_bank cfg2_bank_checker chk_u (.*);

// ===== link_host_model.sv
// host controller model driving the serial register link
`timescale 1ns/1ns
module link_host_model (
  // link pins
  output logic      link_sclk,
  output logic      link_cs_n,
  output logic      link_si,
  input  wire logic link_so,
  input  wire logic link_so_oe
);
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_si = 1'b0;
  end
  // clock only inside frames; si toggles when it carries nothing
  // register reads always use the full 20-cycle gap at 12 ns
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [7:0] wd,
                       input int n, output logic [7:0] rd);
    logic [47:0] bits;
    bits = {op, a, wd};
    rd = 8'h00;
    #5 link_cs_n = 1'b0;
    for (int i = 1; i <= n; i++) begin
      link_si = (i <= 48) ? bits[48-i] : ~link_si;
      #6 link_sclk = 1'b1;
      // data edges follow 40 command edges and the 20-edge gap
      if (i >= 61 && i <= 68) rd = {rd[6:0], link_so_oe ? link_so : 1'bx};
      #6 link_sclk = 1'b0;
    end
    #6 link_cs_n = 1'b1;
    link_si = ~link_si;
    #200;
  endtask
endmodule

// ===== cfg2_bank_tb_top.sv
// self-checking bench for the second configuration register bank
`timescale 1ns/1ns
module cfg2_bank_tb_top;
  logic        core_clk, nrst, link_sclk, link_cs_n, link_si, link_so, link_so_oe;
  logic [1:0]  otp_default_mode;
  logic        otp_parity_check_disable_n, ecc_chunk_fail, check_fail, check_pass;
  logic [2:0]  ecc_fail_kind;
  logic [25:4] ecc_fail_addr;
  logic        double_rate_octal_enable, single_rate_octal_enable, strobe_in_single_rate;
  logic        strobe_precycle, crc_pin_enable, ecc_error_pin_n, parity_check_enable;
  logic        write_enable_latch;
  logic [4:0]  dummy_cycles;
  logic [7:0]  crc_chunk_bytes, r;
  logic [15:0] preamble_word;
  int          failures, checks_done;
  wire  [1:0]  mode_now = {double_rate_octal_enable, single_rate_octal_enable};
  logic [31:0] da [9] = '{32'h0, 32'h200, 32'h300, 32'h400, 32'h500, 32'h800,
                          32'h4000_0000, 32'h8000_0000, 32'h100};
  logic [7:0]  de [9] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0]  md [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
  logic [7:0]  me [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
  logic [7:0]  fe [4] = '{8'hE0, 8'hCD, 8'hAB, 8'h02};

  cfg2_bank dut_u (.*);
  link_host_model host_u (.*);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    host_u.frame(cfg2_pkg::OP_READ2, a, 8'h00, 68, r);
    cmp(16'(r), 16'(e));
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    host_u.frame(cfg2_pkg::OP_WR_ENABLE, 32'h0, 8'h00, 8, r);
    cmp(16'(write_enable_latch), 16'h1);
    host_u.frame(cfg2_pkg::OP_WRITE2, a, d, 48, r);
    cmp(16'(write_enable_latch), 16'h0);
  endtask
  task automatic reset_dut(input logic [1:0] m, input logic fz);
    @(negedge core_clk);
    nrst = 1'b0;
    otp_default_mode = m;
    otp_parity_check_disable_n = fz;
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic ecc(input logic [2:0] k, input logic [25:4] ad);
    @(negedge core_clk);
    ecc_chunk_fail = 1'b1;
    ecc_fail_kind = k;
    ecc_fail_addr = ad;
    @(negedge core_clk);
    ecc_chunk_fail = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic chk(input logic f);
    @(negedge core_clk);
    check_fail = f;
    check_pass = !f;
    @(negedge core_clk);
    check_fail = 1'b0;
    check_pass = 1'b0;
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    finish_test();
  end

  initial begin
    {nrst, ecc_chunk_fail, check_fail, check_pass, ecc_fail_kind, ecc_fail_addr} = '0;
    {otp_default_mode, otp_parity_check_disable_n} = '0;
    reset_dut(2'h1, 1'b0);
    cmp(16'(mode_now), 16'h2);
    cmp(16'(parity_check_enable), 16'h1);
    foreach (da[i]) rd(da[i], de[i]);
    $display("done: defaults");
    // a write with the latch clear must be dropped
    host_u.frame(cfg2_pkg::OP_WRITE2, 32'h300, 8'h05, 48, r);
    rd(32'h300, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(32'h300, 8'hF8 | 8'(i));
      rd(32'h300, 8'(i));
      cmp(16'(dummy_cycles), 16'(20 - 2 * i));
    end
    for (int i = 0; i < 4; i++) begin
      wr(32'h0, md[i]);
      rd(32'h0, me[i]);
      cmp(16'(mode_now), 16'(me[i]));
    end
    for (int j = 0; j < 4; j++) begin
      wr(32'h500, 8'h9E | 8'(j << 5) | 8'(j & 1));
      rd(32'h500, 8'h10 | 8'(j << 5) | 8'(j & 1));
      cmp(16'(crc_chunk_bytes), 16'(16 << j));
      cmp(preamble_word, (j & 1) ? 16'h5555 : 16'h349A);
    end
    cmp(16'(crc_pin_enable), 16'h1);
    wr(32'h200, 8'hFF);
    rd(32'h200, 8'h03);
    cmp(16'({strobe_in_single_rate, strobe_precycle}), 16'h3);
    $display("done: config fields");
    wr(32'h400, 8'h02);
    ecc(3'h1, 22'h2ABCDE);
    cmp(16'(ecc_error_pin_n), 16'h1);
    ecc(3'h2, 22'h012345);
    cmp(16'(ecc_error_pin_n), 16'h0);
    rd(32'h800, 8'hB2);
    for (int i = 0; i < 14; i++) ecc(3'h4, 22'h0);
    wr(32'h800, 8'h00);
    wr(32'hC00, 8'h00);
    rd(32'h800, 8'hFF);
    for (int i = 0; i < 4; i++) rd(32'hC00 + 32'(i << 8), fe[i]);
    chk(1'b1);
    rd(32'h8000_0000, 8'h10);
    chk(1'b0);
    rd(32'h8000_0000, 8'h00);
    $display("done: ecc and check");
    reset_dut(2'h2, 1'b1);
    cmp(16'(mode_now), 16'h1);
    cmp(16'(parity_check_enable), 16'h0);
    rd(32'h4000_0000, 8'h0A);
    rd(32'h800, 8'h00);
    // double-program only: counted, pin low under condition 00, no capture
    ecc(3'h4, 22'h0);
    cmp(16'(ecc_error_pin_n), 16'h0);
    rd(32'h800, 8'h41);
    wr(32'h400, 8'h03);
    cmp(16'(ecc_error_pin_n), 16'h1);
    reset_dut(2'h3, 1'b1);
    cmp(16'(mode_now), 16'h0);
    reset_dut(2'h0, 1'b1);
    cmp(16'(mode_now), 16'h0);
    $display("done: fuse defaults");
    finish_test();
  end
endmodule
